// >>> shared/fars_pkg.sv
// Package: constants and carrier types of the fault auto restart sequencer
package fars_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_TIME_NS = 100_000_000;
  localparam int unsigned TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned QUIET_TIME_S = 600;
  localparam logic [12:0] QUIET_TICKS = 13'(QUIET_TIME_S * 10);
  localparam int unsigned TW = 13;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_CONTINUE = 5'h04;
  localparam logic [4:0] OFS_INTERVAL = 5'h08;
  localparam logic [4:0] OFS_BASEBLOCK = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_COMMAND = 5'h14;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h18;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h1C;

  ////////////////////////////////////////////////////////////////////////////////
  // Control, command and status field positions
  localparam int unsigned CTRL_LIMIT_LSB = 0;
  localparam int unsigned CTRL_FOUT_BIT = 4;
  localparam int unsigned CTRL_MODE_BIT = 5;
  localparam int unsigned CTRL_RIDE_LSB = 8;
  localparam int unsigned CTRL_DOUT_LSB = 16;
  localparam int unsigned CMD_RESET_BIT = 0;
  localparam int unsigned STAT_COUNT_LSB = 8;
  localparam int unsigned STAT_ELAPSED_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and limits (times in 0.1 s units)
  localparam logic [3:0] LIMIT_RESET = 4'h0;
  localparam logic [3:0] LIMIT_MAX = 4'hA;
  localparam logic [12:0] CONTINUE_RESET = 13'h0708;
  localparam logic [12:0] CONTINUE_MAX = 13'h1770;
  localparam logic [12:0] INTERVAL_RESET = 13'h0064;
  localparam logic [12:0] INTERVAL_MIN = 13'h0005;
  localparam logic [12:0] INTERVAL_MAX = 13'h1770;
  localparam logic [12:0] BASEBLOCK_RESET = 13'h0005;
  localparam logic [2:0] RIDE_MIN = 3'h1;
  localparam logic [2:0] RIDE_MAX = 3'h4;
  localparam logic [7:0] DOUT_FUNC_RESTART = 8'h1E;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt events
  localparam int unsigned EV_RESTART = 0;
  localparam int unsigned EV_LOCKOUT = 1;
  localparam int unsigned EV_TIMEOUT = 2;
  localparam int unsigned EV_CLEARED = 3;
  localparam int unsigned EV_N = 4;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_BASEBLOCK = 3'b001,
    ST_CHECK = 3'b010,
    ST_SEARCH = 3'b011,
    ST_INTERVAL = 3'b100,
    ST_LOCKOUT = 3'b101,
    ST_STOPPED = 3'b110
  } fars_state_t;

  typedef struct packed {
    logic other_fault;
    logic pull_out_fault;
    logic bus_undervoltage_fault;
    logic input_phase_loss_fault;
    logic bus_overvoltage_fault;
    logic overtorque_one_fault;
    logic drive_overload_fault;
    logic motor_overload_fault;
    logic drive_overheat_fault;
    logic overcurrent_fault;
    logic output_open_phase_fault;
    logic ground_fault;
  } fars_faults_t;

  typedef struct packed {
    logic [7:0] digital_output_function_select;
    logic [2:0] power_loss_ride_through_select;
    logic restart_count_mode;
    logic restart_fault_output_select;
    logic [3:0] restart_attempt_limit;
    logic [12:0] restart_continue_timeout;
    logic [12:0] restart_interval_time;
    logic [12:0] baseblock_time;
  } fars_cfg_t;

endpackage

// >>> src/fars_tick.sv
// Prescaler producing the 0.1 s timer tick
`timescale 1ns/100ps
module fars_tick #(
  parameter int unsigned TICK_CYCLES = fars_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Tick
  output logic tick
);

  logic [31:0] cnt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt >= 32'(TICK_CYCLES - 1)) begin
      cnt <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end

endmodule

// >>> src/fars_fault_class.sv
// Sorts the active faults into restartable and stopping ones
`timescale 1ns/100ps
module fars_fault_class (
  // Fault detectors
  input fars_pkg::fars_faults_t faults,
  input wire logic [2:0] ride_select,
  // Classification
  output logic any_fault,
  output logic restartable
);

  logic uv_ok;
  logic hard;

  always_comb begin
    uv_ok = (ride_select >= fars_pkg::RIDE_MIN) && (ride_select <= fars_pkg::RIDE_MAX);
    // Any fault outside the restartable set stops the drive
    hard = faults.other_fault || (faults.bus_undervoltage_fault && !uv_ok);
    any_fault = |faults;
    restartable = any_fault && !hard;
  end

endmodule

// >>> src/fars_top.sv
// Fault auto restart sequencer with Avalon-MM register slave
`timescale 1ns/100ps
module fars_top #(
  parameter int unsigned TICK_CYCLES = fars_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq,
  // Fault detectors and output stage
  input fars_pkg::fars_faults_t faults,
  input wire logic search_done,
  input wire logic search_fail,
  output logic baseblock,
  output logic speed_search_start,
  output logic drive_stop,
  output logic fault_relay_output,
  output logic digital_output
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam int unsigned EV_W = fars_pkg::EV_N;
  fars_pkg::fars_cfg_t cfg;
  fars_pkg::fars_state_t state;
  logic tick;
  logic any_fault;
  logic restartable;
  logic ack;
  logic wr_en;
  logic [31:0] wmask;
  logic [31:0] wdata;
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] ev;
  logic manual_reset;
  logic [3:0] count;
  logic [12:0] timer;
  logic [12:0] elapsed;
  logic [12:0] quiet;
  logic limit_hit;
  logic timed_out;
  logic restarting;
  logic start_try;
  logic try_ok;
  logic try_bad;
  logic to_lockout;
  logic quiet_clear;

  fars_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick)
  );

  fars_fault_class u_class (
    .faults(faults),
    .ride_select(cfg.power_loss_ride_through_select),
    .any_fault(any_fault),
    .restartable(restartable)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait state on every access
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign wr_en = avs_write && ack;
  assign manual_reset = wr_en && (avs_address == fars_pkg::OFS_COMMAND)
    && avs_byteenable[0] && avs_writedata[fars_pkg::CMD_RESET_BIT];

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{avs_byteenable[b]}};
    end
    wdata = avs_writedata & wmask;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  // Read data is loaded in the wait cycle so it stands when waitrequest drops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack) begin
      avs_readdata <= 32'h00000000;
      case (avs_address)
        fars_pkg::OFS_CTRL: begin
          avs_readdata[fars_pkg::CTRL_LIMIT_LSB +: 4] <= cfg.restart_attempt_limit;
          avs_readdata[fars_pkg::CTRL_FOUT_BIT] <= cfg.restart_fault_output_select;
          avs_readdata[fars_pkg::CTRL_MODE_BIT] <= cfg.restart_count_mode;
          avs_readdata[fars_pkg::CTRL_RIDE_LSB +: 3] <= cfg.power_loss_ride_through_select;
          avs_readdata[fars_pkg::CTRL_DOUT_LSB +: 8] <= cfg.digital_output_function_select;
        end
        fars_pkg::OFS_CONTINUE: avs_readdata[12:0] <= cfg.restart_continue_timeout;
        fars_pkg::OFS_INTERVAL: avs_readdata[12:0] <= cfg.restart_interval_time;
        fars_pkg::OFS_BASEBLOCK: avs_readdata[12:0] <= cfg.baseblock_time;
        fars_pkg::OFS_STATUS: begin
          avs_readdata[2:0] <= state;
          avs_readdata[fars_pkg::STAT_COUNT_LSB +: 4] <= count;
          avs_readdata[fars_pkg::STAT_ELAPSED_LSB +: 13] <= elapsed;
        end
        fars_pkg::OFS_IRQ_STATUS: avs_readdata[EV_W-1:0] <= irq_status;
        fars_pkg::OFS_IRQ_MASK: avs_readdata[EV_W-1:0] <= irq_mask;
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers, out-of-range limit, continue and interval values are clamped on write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg.restart_attempt_limit <= fars_pkg::LIMIT_RESET;
      cfg.restart_fault_output_select <= 1'b0;
      cfg.restart_count_mode <= 1'b0;
      cfg.power_loss_ride_through_select <= 3'h0;
      cfg.digital_output_function_select <= 8'h00;
      cfg.restart_continue_timeout <= fars_pkg::CONTINUE_RESET;
      cfg.restart_interval_time <= fars_pkg::INTERVAL_RESET;
      cfg.baseblock_time <= fars_pkg::BASEBLOCK_RESET;
    end else if (wr_en) begin
      case (avs_address)
        fars_pkg::OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            cfg.restart_attempt_limit <= (wdata[3:0] > fars_pkg::LIMIT_MAX) ?
              fars_pkg::LIMIT_MAX : wdata[3:0];
            cfg.restart_fault_output_select <= wdata[fars_pkg::CTRL_FOUT_BIT];
            cfg.restart_count_mode <= wdata[fars_pkg::CTRL_MODE_BIT];
          end
          if (avs_byteenable[1]) begin
            cfg.power_loss_ride_through_select <= wdata[fars_pkg::CTRL_RIDE_LSB +: 3];
          end
          if (avs_byteenable[2]) begin
            cfg.digital_output_function_select <= wdata[fars_pkg::CTRL_DOUT_LSB +: 8];
          end
        end
        fars_pkg::OFS_CONTINUE: begin
          if (avs_byteenable[0] || avs_byteenable[1]) begin
            cfg.restart_continue_timeout <= (wdata[12:0] > fars_pkg::CONTINUE_MAX) ?
              fars_pkg::CONTINUE_MAX : wdata[12:0];
          end
        end
        fars_pkg::OFS_INTERVAL: begin
          if (avs_byteenable[0] || avs_byteenable[1]) begin
            cfg.restart_interval_time <= (wdata[12:0] < fars_pkg::INTERVAL_MIN) ?
              fars_pkg::INTERVAL_MIN : (wdata[12:0] > fars_pkg::INTERVAL_MAX) ?
              fars_pkg::INTERVAL_MAX : wdata[12:0];
          end
        end
        fars_pkg::OFS_BASEBLOCK: begin
          if (avs_byteenable[0] || avs_byteenable[1]) begin
            cfg.baseblock_time <= wdata[12:0];
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer decisions
  assign limit_hit = count >= cfg.restart_attempt_limit;
  assign restarting = (state == fars_pkg::ST_BASEBLOCK) || (state == fars_pkg::ST_CHECK)
    || (state == fars_pkg::ST_SEARCH) || (state == fars_pkg::ST_INTERVAL);
  assign timed_out = restarting && !cfg.restart_count_mode
    && (elapsed >= cfg.restart_continue_timeout);
  // A try is only made once the fault has cleared after baseblock
  assign start_try = (state == fars_pkg::ST_CHECK) && !timed_out && !any_fault
    && !(cfg.restart_count_mode && limit_hit);
  assign try_ok = (state == fars_pkg::ST_SEARCH) && search_done;
  assign try_bad = (state == fars_pkg::ST_SEARCH) && !search_done
    && (search_fail || any_fault);
  // A stopping fault in mid-restart must not wait for the check state
  assign to_lockout = (state != fars_pkg::ST_LOCKOUT) && (timed_out
    || (restarting && any_fault && !restartable)
    || (state == fars_pkg::ST_RUN && restartable && limit_hit)
    || (state == fars_pkg::ST_CHECK && cfg.restart_count_mode && limit_hit));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= fars_pkg::ST_RUN;
      timer <= 13'h0000;
    end else begin
      unique case (state)
        fars_pkg::ST_RUN: begin
          if (any_fault && !restartable) begin
            state <= fars_pkg::ST_STOPPED;
          end else if (to_lockout) begin
            state <= fars_pkg::ST_LOCKOUT;
          end else if (restartable) begin
            state <= fars_pkg::ST_BASEBLOCK;
            timer <= cfg.baseblock_time;
          end
        end
        fars_pkg::ST_BASEBLOCK: begin
          if (to_lockout) begin
            state <= fars_pkg::ST_LOCKOUT;
          end else if (timer == 13'h0000) begin
            state <= fars_pkg::ST_CHECK;
          end else if (tick) begin
            timer <= timer - 13'h0001;
          end
        end
        fars_pkg::ST_CHECK: begin
          if (to_lockout) begin
            state <= fars_pkg::ST_LOCKOUT;
          end else if (any_fault && !restartable) begin
            state <= fars_pkg::ST_STOPPED;
          end else if (any_fault && cfg.restart_count_mode) begin
            state <= fars_pkg::ST_INTERVAL;
            timer <= cfg.restart_interval_time;
          end else if (start_try) begin
            state <= fars_pkg::ST_SEARCH;
          end
        end
        fars_pkg::ST_SEARCH: begin
          if (to_lockout) begin
            state <= fars_pkg::ST_LOCKOUT;
          end else if (try_ok) begin
            state <= fars_pkg::ST_RUN;
          end else if (try_bad && cfg.restart_count_mode) begin
            state <= fars_pkg::ST_INTERVAL;
            timer <= cfg.restart_interval_time;
          end else if (try_bad) begin
            // Continuous retry goes straight back through baseblock
            state <= fars_pkg::ST_BASEBLOCK;
            timer <= cfg.baseblock_time;
          end
        end
        fars_pkg::ST_INTERVAL: begin
          if (to_lockout) begin
            state <= fars_pkg::ST_LOCKOUT;
          end else if (timer == 13'h0000) begin
            state <= fars_pkg::ST_BASEBLOCK;
            timer <= cfg.baseblock_time;
          end else if (tick) begin
            timer <= timer - 13'h0001;
          end
        end
        fars_pkg::ST_LOCKOUT, fars_pkg::ST_STOPPED: begin
          if (manual_reset && !any_fault) begin
            state <= fars_pkg::ST_RUN;
          end
        end
        default: state <= fars_pkg::ST_STOPPED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Restart counter and its clearing
  assign quiet_clear = (state == fars_pkg::ST_RUN) && tick
    && (count != 4'h0) && (quiet >= fars_pkg::QUIET_TICKS - 13'h0001);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 4'h0;
    end else if (manual_reset || quiet_clear) begin
      count <= 4'h0;
    end else if (start_try && state == fars_pkg::ST_CHECK && cfg.restart_count_mode) begin
      count <= count + 4'h1;
    end else if (try_ok && !cfg.restart_count_mode) begin
      count <= count + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      quiet <= 13'h0000;
    end else if (state != fars_pkg::ST_RUN || any_fault || count == 4'h0) begin
      quiet <= 13'h0000;
    end else if (tick && quiet < fars_pkg::QUIET_TICKS) begin
      quiet <= quiet + 13'h0001;
    end
  end

  // Time spent restarting since the fault, for the continue timeout
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      elapsed <= 13'h0000;
    end else if (!restarting) begin
      elapsed <= 13'h0000;
    end else if (tick && elapsed != 13'h1FFF) begin
      elapsed <= elapsed + 13'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs to the output stage and terminals
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      baseblock <= 1'b0;
      speed_search_start <= 1'b0;
      drive_stop <= 1'b0;
      fault_relay_output <= 1'b0;
      digital_output <= 1'b0;
    end else begin
      baseblock <= restarting && (state != fars_pkg::ST_SEARCH) && !start_try;
      speed_search_start <= start_try && (state == fars_pkg::ST_CHECK)
        && !(any_fault && !restartable);
      drive_stop <= (state == fars_pkg::ST_LOCKOUT) || (state == fars_pkg::ST_STOPPED);
      fault_relay_output <= (state == fars_pkg::ST_LOCKOUT) || (state == fars_pkg::ST_STOPPED)
        || (restarting && cfg.restart_fault_output_select);
      digital_output <= (cfg.digital_output_function_select == fars_pkg::DOUT_FUNC_RESTART)
        && (restarting || (state == fars_pkg::ST_RUN && !limit_hit));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky events, write one to clear, a new event wins the clear
  always_comb begin
    ev = '0;
    ev[fars_pkg::EV_RESTART] = speed_search_start;
    ev[fars_pkg::EV_LOCKOUT] = to_lockout || (state == fars_pkg::ST_RUN && any_fault
      && !restartable);
    ev[fars_pkg::EV_TIMEOUT] = timed_out;
    ev[fars_pkg::EV_CLEARED] = quiet_clear;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else begin
      if (wr_en && avs_address == fars_pkg::OFS_IRQ_STATUS) begin
        irq_status <= (irq_status & ~wdata[EV_W-1:0]) | ev;
      end else begin
        irq_status <= irq_status | ev;
      end
      if (wr_en && avs_address == fars_pkg::OFS_IRQ_MASK) begin
        irq_mask <= wdata[EV_W-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule

// >>> dv/fars_asserts.sv
// Port checker of the fault auto restart sequencer
`timescale 1ns/100ps
module fars_asserts #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Link
  input fars_pkg::fars_faults_t faults,
  input wire logic baseblock,
  input wire logic speed_search_start,
  input wire logic drive_stop,
  input wire logic fault_relay_output,
  input wire logic digital_output,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Slack of two ticks for where the prescaler stands at entry
  localparam int unsigned BB_MIN = 3 * TICK_CYCLES;
  logic [15:0] bb_cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bb_cnt <= 16'h0000;
    end else begin
      bb_cnt <= baseblock ? bb_cnt + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////
  property p_ss_pulse;
    speed_search_start |=> !speed_search_start;
  endproperty
  a_ss_pulse: assert property (p_ss_pulse) else $error("search start too long");
  property p_ss_after_bb;
    speed_search_start |-> $past(baseblock) && !baseblock;
  endproperty
  a_ss_after_bb: assert property (p_ss_after_bb) else $error("search without block");
  property p_ss_clear;
    speed_search_start |-> $past(faults) == '0;
  endproperty
  a_ss_clear: assert property (p_ss_clear) else $error("search with fault");
  property p_bus_ws;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_ws: assert property (p_bus_ws) else $error("bus wait too long");
  property p_other_stop;
    $rose(faults.other_fault) |-> ##[1:3] drive_stop;
  endproperty
  a_other_stop: assert property (p_other_stop) else $error("other fault no stop");
  property p_stop_quiet;
    drive_stop |-> !speed_search_start;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("search while stopped");
  property p_stop_relay;
    drive_stop && $past(drive_stop) |-> fault_relay_output;
  endproperty
  a_stop_relay: assert property (p_stop_relay) else $error("relay low in stop");
  property p_stop_dout;
    drive_stop && $past(drive_stop) |-> !digital_output;
  endproperty
  a_stop_dout: assert property (p_stop_dout) else $error("dout high in stop");
  property p_bb_len;
    $fell(baseblock) && !drive_stop |-> bb_cnt >= BB_MIN;
  endproperty
  a_bb_len: assert property (p_bb_len) else $error("baseblock too short");
  c_search: cover property (speed_search_start);
  c_stop: cover property ($rose(drive_stop));
  c_irq: cover property ($rose(irq));
endmodule
bind fars_top fars_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk), .arst_n(arst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .faults(faults), .baseblock(baseblock), .speed_search_start(speed_search_start),
  .drive_stop(drive_stop), .fault_relay_output(fault_relay_output),
  .digital_output(digital_output), .irq(irq));

// >>> dv/fars_stage.sv
// Output stage model answering speed search requests
`timescale 1ns/100ps
module fars_stage (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Bench control
  input wire logic fail_mode,
  input wire logic slow,
  // Link
  input wire logic speed_search_start,
  output logic search_done,
  output logic search_fail
);
  logic [3:0] left;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      left <= 4'h0;
      search_done <= 1'b0;
      search_fail <= 1'b0;
    end else begin
      search_done <= 1'b0;
      search_fail <= 1'b0;
      if (speed_search_start) begin
        left <= slow ? 4'h8 : 4'h1;
      end else if (left != 4'h0) begin
        left <= left - 4'h1;
        // Failed rotation tries only when the bench asks for them
        search_done <= left == 4'h1 && !fail_mode;
        search_fail <= left == 4'h1 && fail_mode;
      end
    end
  end
endmodule

// >>> dv/fars_top_tb_top.sv
// Self-checking testbench of the fault auto restart sequencer
`timescale 1ns/100ps
module fars_top_tb_top;
  localparam int unsigned TC = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, v;
  logic wrq, irq, sd, sf, bb, sss, dstop, relay, dout;
  logic fail_mode = 1'b0;
  logic slow = 1'b0;
  fars_pkg::fars_faults_t flt = '0;
  int miscompares = 0;
  int n_compared = 0;
  int waited;
  initial forever #4 clk = ~clk;
  fars_top #(.TICK_CYCLES(TC)) u_dut (.clk(clk), .arst_n(arst_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_byteenable(4'hF), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wrq), .irq(irq), .faults(flt),
    .search_done(sd), .search_fail(sf), .baseblock(bb), .speed_search_start(sss),
    .drive_stop(dstop), .fault_relay_output(relay), .digital_output(dout));
  fars_stage u_stage (.clk(clk), .arst_n(arst_n), .fail_mode(fail_mode), .slow(slow),
    .speed_search_start(sss), .search_done(sd), .search_fail(sf));
  ////////////////////////////////////////
  task automatic wrap_up();
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tmo();
    miscompares++;
    $display("[FAIL] %0t wait ran out", $time);
    wrap_up();
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wrq !== 1'b0 && n < 50);
    if (wrq !== 1'b0) tmo();
    v = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  function automatic logic sig(input int k);
    logic [3:0] s;
    s = {irq, dstop, bb, sss};
    return s[k];
  endfunction
  task automatic wait_for(input int k, input int lim);
    waited = 0;
    do begin
      @(negedge clk);
      waited++;
    end while (sig(k) !== 1'b1 && waited < lim);
    if (sig(k) !== 1'b1) tmo();
  endtask
  task automatic pwr(input logic [31:0] ctrl);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    bus(1'b1, fars_pkg::OFS_CTRL, ctrl);
  endtask
  task automatic hit(input int b, input logic hold);
    @(posedge clk);
    flt <= fars_pkg::fars_faults_t'(12'h001 << b);
    @(posedge clk);
    if (!hold) flt <= '0;
  endtask
  task automatic rd_count(input logic [3:0] exp);
    bus(1'b0, fars_pkg::OFS_STATUS, 32'h0);
    chk(32'(v[11:8]), 32'(exp));
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] exp [4];
    exp = '{32'h0, 32'h708, 32'h64, 32'h5};
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 5'(i * 4), 32'h0);
      chk(v, exp[i]);
    end
    bus(1'b1, fars_pkg::OFS_INTERVAL, 32'h0);
    bus(1'b0, fars_pkg::OFS_INTERVAL, 32'h0);
    chk(v, 32'h5);
    bus(1'b1, fars_pkg::OFS_CTRL, 32'hF);
    bus(1'b0, fars_pkg::OFS_CTRL, 32'h0);
    chk(v, 32'hA);
  endtask
  task automatic t_classes();
    for (int b = 0; b < 13; b++) begin
      pwr(b == 12 ? 32'h10A : 32'h00A);
      hit(b == 12 ? 9 : b, 1'b0);
      repeat (4) @(negedge clk);
      chk(32'(bb), 32'(b != 9 && b != 11));
      chk(32'(dstop), 32'(b == 9 || b == 11));
    end
  endtask
  task automatic t_lock();
    pwr(32'h0);
    bus(1'b1, fars_pkg::OFS_IRQ_MASK, 32'h2);
    hit(3, 1'b0);
    wait_for(2, 10);
    wait_for(3, 10);
  endtask
  task automatic t_restart();
    pwr(32'h1E0012);
    bus(1'b1, fars_pkg::OFS_IRQ_MASK, 32'h8);
    @(negedge clk);
    chk(32'(dout), 32'h1);
    hit(2, 1'b0);
    wait_for(1, 10);
    chk(32'(relay), 32'h1);
    wait_for(0, 200);
    repeat (12) @(negedge clk);
    chk(32'(relay), 32'h0);
    rd_count(4'h1);
    bus(1'b0, fars_pkg::OFS_IRQ_STATUS, 32'h0);
    chk(32'(v[0]), 32'h1);
    chk(32'(irq), 32'h0);
    // Quiet run of six thousand ticks clears the count
    repeat (6000 * TC + 20) @(negedge clk);
    rd_count(4'h0);
    chk(32'(irq), 32'h1);
    bus(1'b1, fars_pkg::OFS_IRQ_STATUS, 32'hF);
    @(negedge clk);
    chk(32'(irq), 32'h0);
  endtask
  task automatic t_attempts();
    pwr(32'h1E0022);
    bus(1'b1, fars_pkg::OFS_INTERVAL, 32'h5);
    fail_mode <= 1'b1;
    slow <= 1'b1;
    hit(2, 1'b1);
    wait_for(1, 10);
    chk(32'(relay), 32'h0);
    repeat (120) @(negedge clk);
    rd_count(4'h0);
    @(posedge clk);
    flt <= '0;
    wait_for(0, 200);
    @(negedge clk);
    wait_for(0, 300);
    chk(32'(waited >= 32), 32'h1);
    wait_for(2, 300);
    rd_count(4'h2);
    fail_mode <= 1'b0;
    bus(1'b1, fars_pkg::OFS_COMMAND, 32'h1);
    repeat (2) @(negedge clk);
    chk(32'(dstop), 32'h0);
    rd_count(4'h0);
  endtask
  task automatic t_timeout();
    pwr(32'h00A);
    bus(1'b1, fars_pkg::OFS_CONTINUE, 32'h3);
    hit(3, 1'b1);
    wait_for(2, 200);
    bus(1'b0, fars_pkg::OFS_IRQ_STATUS, 32'h0);
    chk(32'(v[2]), 32'h1);
    @(posedge clk);
    flt <= '0;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_classes();
    t_lock();
    t_restart();
    t_attempts();
    t_timeout();
    wrap_up();
  end
endmodule
